// ==== hdl/aos_scheduler.v ====
`timescale 1ns/1ps
`default_nettype none
`include "aos_regs.vh"

module aos_scheduler #(
    parameter CLK_HZ = 50000000,
    parameter FIFO_DEPTH = 32
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_cmd_valid,
    input wire i_cmd_write,
    input wire [7:0] i_cmd_reg_id,
    input wire [31:0] i_cmd_data,
    input wire i_cmd_port_given,
    input wire [7:0] i_cmd_port_sel,
    input wire i_cmd_src_port,
    input wire [2:0] i_src_refresh,
    output reg o_rsp_valid,
    output reg o_rsp_ok,
    output reg [7:0] o_rsp_reg_id,
    output reg [31:0] o_rsp_data,
    output reg o_rsp_port_given,
    output reg [7:0] o_rsp_port_sel,
    output reg o_pkt_valid,
    input wire i_pkt_ready,
    output reg o_pkt_port,
    output reg [7:0] o_pkt_type
);
    localparam ST_PREFER0 = 2'b01;
    localparam ST_PREFER1 = 2'b10;

    function type_ok;
        input [31:0] v;
        begin
            type_ok = (v == {24'h000000, `AOS_TYPE_OFF}) ||
                      (v == {24'h000000, `AOS_TYPE_INERTIAL}) ||
                      (v == {24'h000000, `AOS_TYPE_POSITIONING}) ||
                      (v == {24'h000000, `AOS_TYPE_NAVIGATION});
        end
    endfunction

    // cycles between paced slots; zero marks a rate that is not accepted
    function [31:0] period;
        input [31:0] hz;
        begin
            if (hz[31:8] != 24'h000000) begin
                period = 32'h00000000;
            end else begin
                case (hz[7:0])
                    `AOS_HZ_1: period = CLK_HZ / `AOS_HZ_1;
                    `AOS_HZ_2: period = CLK_HZ / `AOS_HZ_2;
                    `AOS_HZ_4: period = CLK_HZ / `AOS_HZ_4;
                    `AOS_HZ_5: period = CLK_HZ / `AOS_HZ_5;
                    `AOS_HZ_10: period = CLK_HZ / `AOS_HZ_10;
                    `AOS_HZ_20: period = CLK_HZ / `AOS_HZ_20;
                    `AOS_HZ_25: period = CLK_HZ / `AOS_HZ_25;
                    `AOS_HZ_40: period = CLK_HZ / `AOS_HZ_40;
                    `AOS_HZ_50: period = CLK_HZ / `AOS_HZ_50;
                    `AOS_HZ_100: period = CLK_HZ / `AOS_HZ_100;
                    `AOS_HZ_200: period = CLK_HZ / `AOS_HZ_200;
                    default: period = 32'h00000000;
                endcase
            end
        end
    endfunction

    // which refresh strobes feed a given packet type
    function [2:0] src_mask;
        input [7:0] t;
        begin
            src_mask = 3'h0;
            if (t == `AOS_TYPE_INERTIAL) begin
                src_mask[`AOS_SRC_INERTIAL] = 1'b1;
            end else if (t == `AOS_TYPE_POSITIONING) begin
                src_mask[`AOS_SRC_POSITIONING] = 1'b1;
            end else if (t == `AOS_TYPE_NAVIGATION) begin
                src_mask[`AOS_SRC_NAVIGATION] = 1'b1;
            end
        end
    endfunction

    reg [7:0] type_q [0:1];
    reg [7:0] rate_q [0:1];
    reg [31:0] cnt_q [0:1];
    reg [1:0] fresh_q;
    reg [1:0] due_q;
    reg [1:0] st_q;

    wire port_ok;
    wire tgt;
    wire wr_type;
    wire wr_rate;
    wire [1:0] want;
    wire [1:0] grant;
    wire push_valid;
    wire push_ready;
    wire push_port;
    wire [8:0] fifo_out;
    wire fifo_valid;
    wire fifo_pop;

    assign port_ok = !i_cmd_port_given || (i_cmd_port_sel == `AOS_PORT_SEL_1) ||
                     (i_cmd_port_sel == `AOS_PORT_SEL_2);
    assign tgt = i_cmd_port_given ? (i_cmd_port_sel == `AOS_PORT_SEL_2)
                                  : i_cmd_src_port;
    assign wr_type = i_cmd_valid && i_cmd_write && port_ok &&
                     (i_cmd_reg_id == `AOS_REG_OUTPUT_TYPE) && type_ok(i_cmd_data);
    assign wr_rate = i_cmd_valid && i_cmd_write && port_ok &&
                     (i_cmd_reg_id == `AOS_REG_OUTPUT_RATE) &&
                     (period(i_cmd_data) != 32'h00000000);

    assign want[0] = due_q[0] && fresh_q[0] && (type_q[0] != `AOS_TYPE_OFF);
    assign want[1] = due_q[1] && fresh_q[1] && (type_q[1] != `AOS_TYPE_OFF);
    assign grant[0] = push_ready && want[0] && (st_q == ST_PREFER0 || !want[1]);
    assign grant[1] = push_ready && want[1] && !grant[0];
    assign push_valid = |want;
    assign push_port = grant[1] || (!grant[0] && want[1]);
    assign fifo_pop = fifo_valid && (!o_pkt_valid || i_pkt_ready);

    integer p;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (p = 0; p < 2; p = p + 1) begin
                type_q[p] <= `AOS_TYPE_RST;
                rate_q[p] <= `AOS_RATE_RST;
                cnt_q[p] <= 32'h00000000;
            end
            fresh_q <= 2'b00;
            due_q <= 2'b00;
            st_q <= ST_PREFER0;
        end else begin
            for (p = 0; p < 2; p = p + 1) begin
                if (wr_rate && tgt == p) begin
                    rate_q[p] <= i_cmd_data[7:0];
                    cnt_q[p] <= period(i_cmd_data) - 32'h00000001;
                end else if (cnt_q[p] == 32'h00000000) begin
                    cnt_q[p] <= period({24'h000000, rate_q[p]}) - 32'h00000001;
                end else begin
                    cnt_q[p] <= cnt_q[p] - 32'h00000001;
                end
                if (wr_type && tgt == p) begin
                    type_q[p] <= i_cmd_data[7:0];
                    fresh_q[p] <= 1'b0;
                    due_q[p] <= 1'b0;
                end else begin
                    // a refresh landing in the grant cycle is kept for the next slot
                    fresh_q[p] <= (fresh_q[p] && !grant[p]) ||
                                  (|(i_src_refresh & src_mask(type_q[p])));
                    // one paced slot per period; an unfilled slot waits for the refresh
                    due_q[p] <= (type_q[p] != `AOS_TYPE_OFF) &&
                                ((cnt_q[p] == 32'h00000000) ||
                                 (due_q[p] && !grant[p]));
                end
            end
            if (grant[0]) begin
                st_q <= ST_PREFER1;
            end else if (grant[1]) begin
                st_q <= ST_PREFER0;
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp_ok <= 1'b0;
            o_rsp_reg_id <= 8'h00;
            o_rsp_data <= 32'h00000000;
            o_rsp_port_given <= 1'b0;
            o_rsp_port_sel <= 8'h00;
        end else begin
            o_rsp_valid <= i_cmd_valid;
            if (i_cmd_valid) begin
                o_rsp_reg_id <= i_cmd_reg_id;
                o_rsp_port_given <= i_cmd_port_given;
                o_rsp_port_sel <= i_cmd_port_given ? i_cmd_port_sel : 8'h00;
                if (!port_ok) begin
                    o_rsp_ok <= 1'b0;
                    o_rsp_data <= 32'h00000000;
                end else if (i_cmd_reg_id == `AOS_REG_OUTPUT_TYPE) begin
                    o_rsp_ok <= !i_cmd_write || wr_type;
                    o_rsp_data <= {24'h000000, (wr_type ? i_cmd_data[7:0] : type_q[tgt])};
                end else if (i_cmd_reg_id == `AOS_REG_OUTPUT_RATE) begin
                    o_rsp_ok <= !i_cmd_write || wr_rate;
                    o_rsp_data <= {24'h000000, (wr_rate ? i_cmd_data[7:0] : rate_q[tgt])};
                end else begin
                    o_rsp_ok <= 1'b0;
                    o_rsp_data <= 32'h00000000;
                end
            end
        end
    end

    // output stage keeps every packet port on a flip-flop
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pkt_valid <= 1'b0;
            o_pkt_port <= 1'b0;
            o_pkt_type <= 8'h00;
        end else if (!o_pkt_valid || i_pkt_ready) begin
            o_pkt_valid <= fifo_valid;
            if (fifo_valid) begin
                o_pkt_port <= fifo_out[8];
                o_pkt_type <= fifo_out[7:0];
            end
        end
    end

    aos_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(push_valid),
        .o_in_ready(push_ready),
        .i_in_data({push_port, type_q[push_port]}),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out)
    );
endmodule

`default_nettype wire

// ==== hdl/aos_regs.vh ====
`ifndef AOS_REGS_VH
`define AOS_REGS_VH

// register identifiers as carried by the read and write register commands
`define AOS_REG_OUTPUT_TYPE 8'h06
`define AOS_REG_OUTPUT_RATE 8'h07

// output_type_select codes
`define AOS_TYPE_OFF 8'h00
`define AOS_TYPE_INERTIAL 8'h13
`define AOS_TYPE_POSITIONING 8'h14
`define AOS_TYPE_NAVIGATION 8'h16

// optional port selector values
`define AOS_PORT_SEL_1 8'h01
`define AOS_PORT_SEL_2 8'h02

// reset values of the per-port settings
`define AOS_TYPE_RST 8'h00
`define AOS_RATE_RST 8'h28

// accepted output_rate_hz values
`define AOS_HZ_1 8'h01
`define AOS_HZ_2 8'h02
`define AOS_HZ_4 8'h04
`define AOS_HZ_5 8'h05
`define AOS_HZ_10 8'h0a
`define AOS_HZ_20 8'h14
`define AOS_HZ_25 8'h19
`define AOS_HZ_40 8'h28
`define AOS_HZ_50 8'h32
`define AOS_HZ_100 8'h64
`define AOS_HZ_200 8'hc8

// measurement source refresh strobe bit positions
`define AOS_SRC_INERTIAL 0
`define AOS_SRC_POSITIONING 1
`define AOS_SRC_NAVIGATION 2

`endif

// ==== hdl/aos_fifo.v ====
`timescale 1ns/1ps
`default_nettype none

module aos_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam [31:0] DEPTH_W = DEPTH;
    localparam [31:0] DEPTH_M1 = DEPTH - 1;
    localparam [AW:0] FULL = DEPTH_W[AW:0];
    localparam [AW-1:0] LAST = DEPTH_M1[AW-1:0];

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign o_in_ready = (cnt_q != FULL);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign o_out_data = mem_q[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== testbench/aos_sched_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module aos_sched_props (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_reg_id,
    input wire logic [31:0] i_cmd_data,
    input wire logic i_cmd_port_given,
    input wire logic [7:0] i_cmd_port_sel,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_ok,
    input wire logic o_rsp_port_given,
    input wire logic [7:0] o_rsp_port_sel,
    input wire logic o_pkt_valid,
    input wire logic i_pkt_ready,
    input wire logic o_pkt_port,
    input wire logic [7:0] o_pkt_type
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire cw = i_cmd_valid && i_cmd_write;
    wire type_ok = i_cmd_data inside {0, 19, 20, 22};
    wire rate_ok = i_cmd_data inside {1, 2, 4, 5, 10, 20, 25, 40, 50, 100, 200};
    wire sel_bad = i_cmd_port_given && !(i_cmd_port_sel inside {1, 2});
    wire type_wr = cw && i_cmd_reg_id == 8'h06;
    wire rate_wr = cw && i_cmd_reg_id == 8'h07;
    a_reply_next: assert property (i_cmd_valid |=> o_rsp_valid)
        else $error("reply missing");
    a_reply_only: assert property (!i_cmd_valid |=> !o_rsp_valid)
        else $error("reply without command");
    a_echo_given: assert property (i_cmd_valid |=>
        o_rsp_port_given == $past(i_cmd_port_given))
        else $error("selector presence not echoed");
    a_echo_absent: assert property (i_cmd_valid && !i_cmd_port_given |=>
        o_rsp_port_sel == 8'h00)
        else $error("selector echoed when absent");
    a_echo_sel: assert property (i_cmd_valid && i_cmd_port_given |=>
        o_rsp_port_sel == $past(i_cmd_port_sel))
        else $error("selector not echoed");
    a_type_refused: assert property (type_wr && !type_ok |=> !o_rsp_ok)
        else $error("bad type accepted");
    a_type_taken: assert property (type_wr && !sel_bad && type_ok |=> o_rsp_ok)
        else $error("good type refused");
    a_rate_refused: assert property (rate_wr && !rate_ok |=> !o_rsp_ok)
        else $error("bad rate accepted");
    a_rate_taken: assert property (rate_wr && !sel_bad && rate_ok |=> o_rsp_ok)
        else $error("good rate refused");
    a_sel_refused: assert property (i_cmd_valid && sel_bad |=> !o_rsp_ok)
        else $error("bad selector accepted");
    a_pkt_code: assert property (o_pkt_valid |-> o_pkt_type inside {8'h13, 8'h14, 8'h16})
        else $error("packet type illegal");
    a_pkt_hold: assert property (o_pkt_valid && !i_pkt_ready |=> o_pkt_valid &&
        $stable(o_pkt_type) && $stable(o_pkt_port))
        else $error("packet request dropped");
endmodule
bind aos_scheduler aos_sched_props u_props (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_write,
    .i_cmd_reg_id, .i_cmd_data, .i_cmd_port_given, .i_cmd_port_sel, .o_rsp_valid, .o_rsp_ok,
    .o_rsp_port_given, .o_rsp_port_sel, .o_pkt_valid, .i_pkt_ready, .o_pkt_port, .o_pkt_type);
`default_nettype wire

// ==== testbench/aos_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module aos_host (
    input wire logic i_clk,
    output logic o_valid = 1'b0,
    output logic o_write = 1'b0,
    output logic [7:0] o_reg_id = 8'h00,
    output logic [31:0] o_data = 32'h00000000,
    output logic o_given = 1'b0,
    output logic [7:0] o_sel = 8'h00,
    output logic o_src = 1'b0
);
    task send(input logic w, input logic [7:0] id, input logic [31:0] d, input logic g,
        input logic [7:0] s, input logic src);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_write <= w;
        o_reg_id <= id;
        o_data <= d;
        o_given <= g;
        o_sel <= s;
        o_src <= src;
        @(posedge i_clk);
        o_valid <= 1'b0;
        // released data, selector and register id scramble so nothing relies on their stale values
        o_data <= ~d;
        o_sel <= ~s;
        o_reg_id <= ~id;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        errors++; \
        $display("[ERR] %0t %h %h", $time, (a), (b)); \
    end \
end
module tb;
    typedef struct packed {logic w; logic [7:0] id; logic [31:0] d; logic g; logic [7:0] s;
        logic src; logic ok; logic [31:0] e;} aos_row_t;
    logic i_clk = 0, i_rst_n = 0, i_pkt_ready = 1;
    logic [2:0] i_src_refresh = 3'h0;
    wire i_cmd_valid, i_cmd_write, i_cmd_port_given, i_cmd_src_port;
    wire o_rsp_valid, o_rsp_ok, o_rsp_port_given, o_pkt_valid, o_pkt_port;
    wire [7:0] i_cmd_reg_id, i_cmd_port_sel, o_rsp_reg_id, o_rsp_port_sel, o_pkt_type;
    wire [31:0] i_cmd_data, o_rsp_data;
    int errors = 0, samples_checked = 0, pkts = 0;
    wire [50:0] rsp_all = {o_rsp_valid, o_rsp_ok, o_rsp_reg_id, o_rsp_data, o_rsp_port_given,
        o_rsp_port_sel};
    logic [50:0] rsp_exp;
    logic [8:0] exp_pkt = 9'h113;
    logic [7:0] tcode[2] = '{8'h14, 8'h16};
    logic [2:0] tsrc[2] = '{3'h2, 3'h4};
    int rates[11] = '{1, 2, 4, 5, 10, 20, 25, 40, 50, 100, 200};
    aos_row_t rows[14] = '{
        '{0, 6, 0, 0, 0, 0, 1, 0},
        '{0, 7, 0, 1, 1, 1, 1, 'h28},
        '{1, 6, 'h13, 0, 0, 1, 1, 'h13},
        '{0, 6, 0, 1, 2, 0, 1, 'h13},
        '{0, 6, 0, 1, 1, 1, 1, 0},
        '{1, 6, 'h14, 1, 1, 1, 1, 'h14},
        '{1, 6, 'h16, 0, 0, 0, 1, 'h16},
        '{1, 6, 'h15, 0, 0, 0, 0, 'h16},
        '{1, 6, 'h113, 0, 0, 0, 0, 'h16},
        '{1, 7, 3, 0, 0, 0, 0, 'h28},
        '{1, 7, 'ha, 0, 0, 1, 1, 'ha},
        '{0, 7, 0, 1, 2, 0, 1, 'ha},
        '{0, 6, 0, 1, 3, 0, 0, 0},
        '{0, 8, 0, 0, 0, 0, 0, 0}};
    always #10 i_clk = ~i_clk;
    aos_host host (.i_clk, .o_valid(i_cmd_valid), .o_write(i_cmd_write), .o_reg_id(i_cmd_reg_id),
        .o_data(i_cmd_data), .o_given(i_cmd_port_given), .o_sel(i_cmd_port_sel),
        .o_src(i_cmd_src_port));
    aos_scheduler #(.CLK_HZ(2000)) uut (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_write,
        .i_cmd_reg_id, .i_cmd_data, .i_cmd_port_given, .i_cmd_port_sel, .i_cmd_src_port,
        .i_src_refresh, .o_rsp_valid, .o_rsp_ok, .o_rsp_reg_id, .o_rsp_data, .o_rsp_port_given,
        .o_rsp_port_sel, .o_pkt_valid, .i_pkt_ready, .o_pkt_port, .o_pkt_type);
    // every packet taken must be the one that the running scenario enables
    always @(posedge i_clk) begin
        if (o_pkt_valid && i_pkt_ready) begin
            pkts++;
            `CHK({o_pkt_port, o_pkt_type}, exp_pkt)
        end
    end
    task final_report;
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1;
        @(posedge i_clk);
        #1 `CHK({o_rsp_valid, o_rsp_data, o_pkt_valid}, 34'h0)
        foreach (rows[i]) begin
            host.send(rows[i].w, rows[i].id, rows[i].d, rows[i].g, rows[i].s, rows[i].src);
            rsp_exp = {1'b1, rows[i].ok, rows[i].id, rows[i].e, rows[i].g,
                rows[i].g ? rows[i].s : 8'h00};
            #1 `CHK(rsp_all, rsp_exp)
        end
        foreach (rates[k]) begin
            host.send(1, 7, rates[k], 1, 2, 0);
            #1 `CHK({o_rsp_ok, o_rsp_data}, {1'b1, 32'(rates[k])})
        end
        host.send(1, 6, 0, 1, 1, 0);
        i_src_refresh <= 3'h1;
        #1 pkts = 0;
        repeat (200) @(posedge i_clk);
        #1 `CHK(pkts inside {[18:20]}, 1'b1)
        @(posedge i_clk);
        i_pkt_ready <= 0;
        repeat (40) @(posedge i_clk);
        #1 `CHK(o_pkt_valid, 1'b1)
        host.send(1, 6, 0, 1, 2, 0);
        i_pkt_ready <= 1;
        repeat (10) @(posedge i_clk);
        #1 pkts = 0;
        repeat (100) @(posedge i_clk);
        #1 `CHK(pkts, 0)
        // port 0 at its reset rate; the wrong source must not trigger a packet
        for (int j = 0; j < 2; j++) begin
            host.send(1, 6, tcode[j], 0, 0, 0);
            #1 pkts = 0;
            exp_pkt = {1'b0, tcode[j]};
            repeat (100) @(posedge i_clk);
            #1 `CHK(pkts, 0)
            @(posedge i_clk);
            i_src_refresh <= tsrc[j];
            repeat (200) @(posedge i_clk);
            #1 `CHK(pkts inside {[4:5]}, 1'b1)
            host.send(1, 6, 0, 0, 0, 0);
            i_src_refresh <= 3'h1;
            repeat (10) @(posedge i_clk);
        end
        // a second reset in mid-run brings the settings back to their reset values
        i_rst_n <= 0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1;
        host.send(0, 6, 0, 1, 1, 0);
        #1 `CHK({o_rsp_ok, o_rsp_data}, {1'b1, 32'h00000000})
        host.send(0, 7, 0, 1, 2, 0);
        #1 `CHK({o_rsp_ok, o_rsp_data}, {1'b1, 32'h00000028})
        final_report;
    end
endmodule
`default_nettype wire
